/* File: timestamp_message_buffer_bench.sv */
`timescale 1ns/1ps
module timestamp_message_buffer_bench;
    import tsmb_pkg::*;
    logic        clock = 0;
    logic        rst_n = 0;
    logic        psel, penable, pwrite, pready, pslverr, alarm_req, e;
    logic [7:0]  paddr, slot;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] din = 16'h0002;
    logic [63:0] t;
    logic [4:0]  seq;
    int          err_total = 0;
    int          n_tests = 0;
    logic [7:0]  bad_rec [3] = '{8'h63, 8'h73, 8'hf0};

    initial forever #25 clock = ~clock;

    tsmb_top tsmb_top_inst (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .din(din), .time_now(t), .alarm_req(alarm_req));
    tsmb_master tsmb_master_inst (.clock(clock), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", s, exp, seen);
        end
    endtask

    // Interrupt tail word: status with the re-initialisation bit, record, count, trailer.
    function automatic logic [31:0] alm_tail(input logic re, input logic [7:0] rec,
                                             input logic [4:0] cnt);
        return {2'b00, re, 5'h0, rec, 3'h0, cnt, 8'h0d};
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        tsmb_master_inst.xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a);
        tsmb_master_inst.xfer(1'b0, a, '0, q, e);
    endtask

    // Every message carries the same stamp because the time input is held still.
    task automatic frame(input logic [7:0] rec, input int n, input logic [31:0] m [3]);
        logic [7:0] b [$];
        b = {HDR_READ, 8'h00, rec, 8'(12 * n)};
        for (int k = 0; k < n; k++) begin
            b = {b, m[k][31:24], m[k][23:16], m[k][15:8], m[k][7:0]};
            for (int j = 7; j >= 0; j--) b.push_back(t[8*j +: 8]);
        end
        wr(A_RDREQ, {24'h0, rec});
        rd(A_RDREQ);
        chk("read return", q, 32'h0);
        foreach (b[k]) begin
            rd(A_RDATA);
            chk("frame byte", {23'h0, q[8:0]}, {23'h0, 1'b1, b[k]});
        end
        rd(A_RDATA);
        chk("frame end", 32'(q[8]), 32'h0);
    endtask

    initial begin
        void'($urandom(78));
        t = {$urandom, $urandom};
        slot = 8'(4 + $urandom % 8);
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(A_STAT);
        chk("reinit at start", 32'(q[17]), 32'h1);
        wr(A_RDREQ, 32'h64);
        rd(A_RDREQ);
        chk("unconfigured read", q, 32'h80b0);
        wr(A_WRREQ, 32'h64);
        rd(A_WRREQ);
        chk("write to message record", q, 32'h80b6);
        wr(A_WRREQ, 32'hf0);
        rd(A_WRREQ);
        chk("config write", q, 32'h0);
        foreach (bad_rec[k]) begin
            wr(A_RDREQ, {24'h0, bad_rec[k]});
            rd(A_RDREQ);
            chk("out of range read", q, 32'h80b0);
        end
        rd(8'h28);
        chk("unmapped", 32'(e), 32'h1);
        $display("start-up test done");
        wr(A_SLOT, {24'h0, slot});
        wr(A_EDGE, 32'h27);
        din <= 16'h000d;
        repeat (5) @(posedge clock);
        wr(A_CTRL, 32'h1);
        repeat (2) @(negedge clock);
        chk("alarm raised", 32'(alarm_req), 32'h1);
        rd(A_ALM0);
        seq = q[7:3];
        chk("alarm head", 32'({q[31:8], q[2:0]}), 32'({24'h080202, 3'h0}));
        tsmb_master_inst.alarm(q);
        chk("alarm tail", q, alm_tail(1'b1, 8'h64, 5'h3));
        frame(8'h64, 3, '{32'h02010100, {slot, 24'h008000}, {slot, 24'h018000}});
        $display("first record test done");
        wr(A_CTRL, 32'h2);
        repeat (2) @(negedge clock);
        chk("alarm cleared", 32'(alarm_req), 32'h0);
        @(posedge clock);
        din <= 16'h000c;
        repeat (5) @(posedge clock);
        wr(A_CTRL, 32'h1);
        rd(A_ALM0);
        chk("sequence step", 32'(q[7:3]), 32'(5'(seq + 5'h1)));
        tsmb_master_inst.alarm(q);
        chk("second alarm tail", q, alm_tail(1'b0, 8'h65, 5'h1));
        frame(8'h65, 1, '{{slot, 24'h000000}, 32'h0, 32'h0});
        $display("second record test done");
        wr(A_CTRL, 32'h4);
        rd(A_STAT);
        chk("reinit on changeover", 32'(q[17]), 32'h1);
        tsmb_master_inst.alarm(q);
        chk("unread after reinit", tsmb_master_inst.unread, 32'h1);
        wr(A_DIAG, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rd(A_DIAG);
            chk("diag byte", {24'h0, q[7:0]}, {24'h0, 8'(32'h000c0005 >> (8 * (3 - i)))});
        end
        chk("bus timeouts", tsmb_master_inst.timeouts, 32'h0);
        $display("diagnostic test done");
        give_verdict();
    end

    initial begin
        repeat (100000) @(posedge clock);
        err_total++;
        give_verdict();
    end
endmodule

/* File: tsmb_master.sv */
`timescale 1ns/1ps
// Bus side of the fieldbus master; it fetches records over the register bus.
module tsmb_master
    import tsmb_pkg::*;
(
    // Clock
    input  wire logic        clock,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    import tsmb_pkg::*;

    int timeouts = 0;
    int unread   = 0;

    initial {psel, penable, pwrite, paddr, pwdata} = '0;

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        repeat ($urandom % 3) @(posedge clock);
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) timeouts++;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic alarm(output logic [31:0] a1);
        logic e;
        xfer(1'b0, A_ALM1, '0, a1, e);
        if (a1[29]) unread = 0;
        unread++;
    endtask
endmodule

/* File: tsmb_msg_store.sv */
`timescale 1ns/1ps
// Plain message array; no reset because contents are only read
// below the per-record fill counts, which are reset.
module tsmb_msg_store #(
    parameter int W     = 96,
    parameter int DEPTH = 300,
    parameter int AW    = 9
) (
    // Clock
    input  wire logic          clock,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // Read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];
endmodule

/* File: tsmb_pkg.sv */
package tsmb_pkg;
    // ************************************************
    // Register byte offsets
    // ************************************************
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_EDGE  = 8'h04;
    localparam logic [7:0] A_SLOT  = 8'h08;
    localparam logic [7:0] A_RDREQ = 8'h0c;
    localparam logic [7:0] A_RDATA = 8'h10;
    localparam logic [7:0] A_WRREQ = 8'h14;
    localparam logic [7:0] A_ALM0  = 8'h18;
    localparam logic [7:0] A_ALM1  = 8'h1c;
    localparam logic [7:0] A_DIAG  = 8'h20;
    localparam logic [7:0] A_STAT  = 8'h24;
    localparam int C_FLUSH  = 0;
    localparam int C_ACK    = 1;
    localparam int C_REINIT = 2;
    // ************************************************
    // Record store geometry and numbering
    // ************************************************
    localparam int NREC  = 15;
    localparam int NMSG  = 20;
    localparam int MSGB  = 12;
    localparam int DEPTH = NREC * NMSG;
    localparam logic [7:0] REC_FIRST = 8'h64;
    localparam logic [7:0] REC_LAST  = 8'h72;
    localparam logic [7:0] CFG_REC   = 8'hf0;
    localparam logic [15:0] RET_OK   = 16'h0000;
    localparam logic [15:0] RET_BAD  = 16'h80b0;
    localparam logic [15:0] RET_DENY = 16'h80b6;
    // ************************************************
    // Message and frame codes
    // ************************************************
    localparam logic [1:0] CTL_RISE   = 2'b11;
    localparam logic [1:0] CTL_FALL   = 2'b01;
    localparam logic [7:0] ST_IN      = 8'h80;
    localparam logic [7:0] ST_OUT     = 8'h00;
    localparam logic [7:0] SLOT_MIN   = 8'h04;
    localparam logic [7:0] SLOT_MAX   = 8'h0b;
    localparam logic [7:0] SPEC_SLOT  = 8'h02;
    localparam logic [7:0] SP_START   = 8'h01;
    localparam logic [7:0] SP_CHANGE  = 8'h07;
    localparam logic [7:0] SP_BEGIN   = 8'h01;
    localparam logic [7:0] HDR_READ   = 8'h5e;
    localparam logic [7:0] HEAD_SLOT  = 8'h00;
    localparam logic [1:0] ALM_CODE   = 2'b00;
    localparam logic [5:0] ALM_LEN    = 6'h08;
    localparam logic [7:0] ALM_TYPE   = 8'h02;
    localparam logic [7:0] ALM_SLOT   = 8'h02;
    localparam logic [2:0] ALM_KIND   = 3'h0;
    localparam logic [7:0] ALM_TRAIL  = 8'h0d;
    localparam int RE_BIT = 5;
    localparam logic [23:0] STN_STATUS  = 24'h000c00;
    localparam logic [7:0]  MASTER_ADDR = 8'h05;
    localparam logic [23:0] MOD_DIAG    = 24'h430000;
    localparam logic [55:0] MOD_STAT    = 56'h07820000000000;
    localparam logic [4:0]  DIAG_LAST   = 5'h17;
endpackage

/* File: tsmb_top.sv */
`timescale 1ns/1ps
module tsmb_top
    import tsmb_pkg::*;
#(
    parameter int          NCH    = 16,
    // Arbitrary identifier value.
    parameter logic [15:0] MFR_ID = 16'h0a5c
) (
    // Clock and reset
    input  wire logic            clock,
    input  wire logic            rst_n,
    // APB slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Inputs and time
    input  wire logic [NCH-1:0]  din,
    input  wire logic [63:0]     time_now,
    // Process interrupt request
    output logic                 alarm_req
);
    import tsmb_pkg::*;

    // ************************************************
    // Reset release
    // ************************************************
    logic [1:0] rs_q;
    logic       rst_s_n;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rs_q <= 2'b00;
        end else begin
            rs_q <= {rs_q[0], 1'b1};
        end
    end
    assign rst_s_n = rs_q[1];

    // ************************************************
    // APB decode
    // ************************************************
    logic       wr_acc;
    logic       rd_acc;
    logic       mapped;
    assign mapped = (paddr <= A_STAT) && (paddr[1:0] == 2'b00);
    assign wr_acc = psel && penable && pwrite && mapped;
    assign rd_acc = psel && penable && !pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    logic ctrl_wr;
    logic flush;
    logic ack_req;
    logic reinit_go;
    assign ctrl_wr   = wr_acc && paddr == A_CTRL;
    assign flush     = ctrl_wr && pwdata[C_FLUSH];
    assign ack_req   = ctrl_wr && pwdata[C_ACK];
    assign reinit_go = ctrl_wr && pwdata[C_REINIT];

    // ************************************************
    // Configuration
    // ************************************************
    logic [2*NCH-1:0] edge_q;
    logic [7:0]       slot_q;
    logic             cfg_q;
    logic [15:0]      wr_ret_q;
    logic [7:0]       wnum;
    assign wnum = pwdata[7:0];
    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            edge_q <= '0;
            slot_q <= SLOT_MIN;
        end else if (wr_acc && paddr == A_EDGE) begin
            edge_q <= pwdata[2*NCH-1:0];
        end else if (wr_acc && paddr == A_SLOT) begin
            slot_q <= pwdata[7:0];
        end
    end
    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            cfg_q    <= 1'b0;
            wr_ret_q <= RET_OK;
        end else if (wr_acc && paddr == A_WRREQ) begin
            if (wnum == CFG_REC) begin
                cfg_q    <= 1'b1;
                wr_ret_q <= RET_OK;
            end else if (wnum >= REC_FIRST && wnum <= REC_LAST) begin
                wr_ret_q <= RET_DENY;
            end else begin
                wr_ret_q <= RET_BAD;
            end
        end
    end

    // ************************************************
    // Edge detection
    // ************************************************
    logic [NCH-1:0] din_q;
    logic [NCH-1:0] ev;
    logic [NCH-1:0] inc;
    logic           stamp_on;
    assign stamp_on = cfg_q && slot_q >= SLOT_MIN && slot_q <= SLOT_MAX;
    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            din_q <= '0;
        end else begin
            din_q <= din;
        end
    end
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic [1:0] ctl;
        logic       rise;
        logic       fall;
        assign ctl  = edge_q[2*i+1:2*i];
        assign rise = din[i] && !din_q[i];
        assign fall = !din[i] && din_q[i];
        assign ev[i]  = stamp_on && ctl[0] && (rise || fall);
        assign inc[i] = (ctl == CTL_RISE) ? rise : fall;
    end

    // ************************************************
    // Pending events and selection
    // ************************************************
    logic [NCH-1:0] pend_q;
    logic [NCH-1:0] pin_q;
    logic [NCH-1:0] pick_oh;
    logic [3:0]     pick_idx;
    logic           any;
    always_comb begin
        pick_oh  = '0;
        pick_idx = 4'h0;
        any      = 1'b0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                pick_idx = 4'(i);
                any      = 1'b1;
            end
        end
        pick_oh[pick_idx] = any;
    end

    logic do_sig;
    logic do_spec;
    logic do_wr;
    // A new edge on the channel being written wins over its clear.
    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            pend_q <= '0;
            pin_q  <= '0;
        end else begin
            pend_q <= (pend_q & ~(do_sig ? pick_oh : '0)) | ev;
            pin_q  <= (pin_q & ~ev) | (inc & ev);
        end
    end

    // ************************************************
    // Record bookkeeping
    // ************************************************
    logic [4:0]  rec_cnt_q [NREC];
    logic [3:0]  wr_rec_q;
    logic [3:0]  rd_rec_q;
    logic [3:0]  ncl_q;
    logic [3:0]  ncl_d;
    logic        spec_q;
    logic [7:0]  spec_code_q;
    logic        reinit_q;
    logic        ovf_q;
    logic [4:0]  seq_q;
    logic [4:0]  wr_cnt;
    logic        can_write;
    logic        close;
    logic        ack;
    logic [95:0] wdata;
    logic [8:0]  waddr;

    function automatic logic [3:0] nxt(input logic [3:0] r);
        return (r == 4'(NREC - 1)) ? 4'h0 : r + 4'h1;
    endfunction

    assign wr_cnt    = rec_cnt_q[wr_rec_q];
    assign can_write = ncl_q < 4'(NREC);
    assign do_spec   = spec_q && can_write && !reinit_go;
    assign do_sig    = any && can_write && !spec_q && !reinit_go;
    assign do_wr     = do_spec || do_sig;
    assign close = can_write && !reinit_go &&
                   ((do_wr && wr_cnt == 5'(NMSG - 1)) ||
                    (flush && (wr_cnt != 5'h0 || do_wr)));
    assign ack   = ack_req && ncl_q != 4'h0 && !reinit_go;
    assign ncl_d = ncl_q + {3'h0, close} - {3'h0, ack};
    assign waddr = 9'(wr_rec_q) * 9'(NMSG) + 9'(wr_cnt);
    assign wdata = do_spec ?
        {SPEC_SLOT, spec_code_q, SP_BEGIN, 8'h00, time_now} :
        {slot_q, 4'h0, pick_idx, pin_q[pick_idx] ? ST_IN : ST_OUT,
         8'h00, time_now};

    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            for (int r = 0; r < NREC; r++) begin
                rec_cnt_q[r] <= 5'h0;
            end
        end else begin
            for (int r = 0; r < NREC; r++) begin
                if (reinit_go) begin
                    rec_cnt_q[r] <= 5'h0;
                end else if (do_wr && 4'(r) == wr_rec_q) begin
                    rec_cnt_q[r] <= wr_cnt + 5'h1;
                end else if (close && 4'(r) == nxt(wr_rec_q)
                             && ncl_d < 4'(NREC)) begin
                    rec_cnt_q[r] <= 5'h0;
                end else if (ack && !can_write && 4'(r) == rd_rec_q) begin
                    rec_cnt_q[r] <= 5'h0;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            wr_rec_q <= 4'h0;
            rd_rec_q <= 4'h0;
            ncl_q    <= 4'h0;
        end else if (reinit_go) begin
            wr_rec_q <= 4'h0;
            rd_rec_q <= 4'h0;
            ncl_q    <= 4'h0;
        end else begin
            if (close) begin
                wr_rec_q <= nxt(wr_rec_q);
            end
            if (ack) begin
                rd_rec_q <= nxt(rd_rec_q);
            end
            ncl_q <= ncl_d;
        end
    end

    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            spec_q      <= 1'b1;
            spec_code_q <= SP_START;
        end else if (reinit_go) begin
            spec_q      <= 1'b1;
            spec_code_q <= SP_CHANGE;
        end else if (do_spec) begin
            spec_q      <= 1'b0;
        end
    end

    // re-initialisation flag stays until acknowledged, overflow flag until re-initialisation; a new cause wins.
    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            reinit_q <= 1'b1;
            ovf_q    <= 1'b0;
            seq_q    <= 5'h0;
        end else begin
            if (reinit_go) begin
                reinit_q <= 1'b1;
            end else if (ack) begin
                reinit_q <= 1'b0;
            end
            if (any && !can_write) begin
                ovf_q <= 1'b1;
            end else if (reinit_go) begin
                ovf_q <= 1'b0;
            end
            if (ack) begin
                seq_q <= seq_q + 5'h1;
            end
        end
    end

    logic [8:0]  raddr;
    logic [95:0] rword;

    tsmb_msg_store #(
        .W     (96),
        .DEPTH (DEPTH),
        .AW    (9)
    ) u_store (
        .clock   (clock),
        .wr_en   (do_wr),
        .wr_addr (waddr),
        .wr_data (wdata),
        .rd_addr (raddr),
        .rd_data (rword)
    );

    // ************************************************
    // Interrupt section
    // ************************************************
    logic [7:0]  ts_status;
    logic [31:0] alm0;
    logic [31:0] alm1;
    assign ts_status = 8'(reinit_q) << RE_BIT;
    assign alm0 = {ALM_CODE, ALM_LEN, ALM_TYPE, ALM_SLOT, seq_q, ALM_KIND};
    assign alm1 = {ts_status, REC_FIRST + {4'h0, rd_rec_q},
                   3'h0, rec_cnt_q[rd_rec_q], ALM_TRAIL};
    assign alarm_req = ncl_q != 4'h0;

    // ************************************************
    // Record read frame
    // ************************************************
    logic [15:0] rd_ret_q;
    logic        fval_q;
    logic [3:0]  frec_q;
    logic [4:0]  fcnt_q;
    logic [2:0]  fidx_q;
    logic [4:0]  fmsg_q;
    logic [3:0]  fbyte_q;
    logic        fhave;
    logic [7:0]  fdat;
    logic        rd_ok;
    logic        rdata_rd;
    assign rd_ok = wnum >= REC_FIRST && wnum <= REC_LAST && cfg_q;
    assign raddr = 9'(frec_q) * 9'(NMSG) + 9'(fmsg_q);
    assign fhave = fval_q && (fidx_q < 3'h4 || fmsg_q < fcnt_q);
    assign rdata_rd = rd_acc && paddr == A_RDATA && fhave;
    // header then twelve bytes per message
    always_comb begin
        unique case (fidx_q)
            3'h0:    fdat = HDR_READ;
            3'h1:    fdat = HEAD_SLOT;
            3'h2:    fdat = REC_FIRST + {4'h0, frec_q};
            3'h3:    fdat = 8'(fcnt_q * 8'(MSGB));
            default: fdat = rword[8'(95 - 8 * fbyte_q) -: 8];
        endcase
    end

    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            rd_ret_q <= RET_OK;
            fval_q   <= 1'b0;
            frec_q   <= 4'h0;
            fcnt_q   <= 5'h0;
            fidx_q   <= 3'h0;
            fmsg_q   <= 5'h0;
            fbyte_q  <= 4'h0;
        end else if (wr_acc && paddr == A_RDREQ) begin
            rd_ret_q <= rd_ok ? RET_OK : RET_BAD;
            fval_q   <= rd_ok;
            frec_q   <= 4'(wnum - REC_FIRST);
            fcnt_q   <= rd_ok ? rec_cnt_q[4'(wnum - REC_FIRST)] : 5'h0;
            fidx_q   <= 3'h0;
            fmsg_q   <= 5'h0;
            fbyte_q  <= 4'h0;
        end else if (rdata_rd) begin
            if (fidx_q < 3'h4) begin
                fidx_q <= fidx_q + 3'h1;
            end else if (fbyte_q == 4'(MSGB - 1)) begin
                fbyte_q <= 4'h0;
                fmsg_q  <= fmsg_q + 5'h1;
            end else begin
                fbyte_q <= fbyte_q + 4'h1;
            end
        end
    end

    // ************************************************
    // Diagnostic frame
    // ************************************************
    logic [191:0] diag;
    logic [4:0]   didx_q;
    assign diag = {STN_STATUS, MASTER_ADDR, MFR_ID, MOD_DIAG, MOD_STAT,
                   alm0, alm1};
    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            didx_q <= 5'h0;
        end else if (wr_acc && paddr == A_DIAG) begin
            didx_q <= 5'h0;
        end else if (rd_acc && paddr == A_DIAG) begin
            didx_q <= (didx_q == DIAG_LAST) ? 5'h0 : didx_q + 5'h1;
        end
    end

    // ************************************************
    // Read data, loaded in the setup phase
    // ************************************************
    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                A_EDGE:  prdata <= 32'(edge_q);
                A_SLOT:  prdata <= {24'h0, slot_q};
                A_RDREQ: prdata <= {16'h0, rd_ret_q};
                A_RDATA: prdata <= {23'h0, fhave, fdat};
                A_WRREQ: prdata <= {16'h0, wr_ret_q};
                A_ALM0:  prdata <= alm0;
                A_ALM1:  prdata <= alm1;
                A_DIAG:  prdata <= {24'h0, diag[8'(191 - 8 * didx_q) -: 8]};
                A_STAT:  prdata <= {11'h0, ovf_q, cfg_q, alarm_req, reinit_q,
                                    ncl_q, wr_rec_q, 4'h0, wr_cnt};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_s_n);

    a_bad_range: assert property (wr_acc && paddr == A_RDREQ &&
        (wnum < REC_FIRST || wnum > REC_LAST) |=> rd_ret_q == 16'h80b0)
        else $error("out of range read not refused");
    a_unconfig_read: assert property (wr_acc && paddr == A_RDREQ &&
        !cfg_q |=> rd_ret_q == 16'h80b0 && !fhave)
        else $error("unconfigured read not refused");
    a_cfg_write: assert property (wr_acc && paddr == A_WRREQ &&
        wnum == 8'hf0 |=> wr_ret_q == 16'h0000 && cfg_q)
        else $error("config write not accepted");
    a_fill_limit: assert property (wr_cnt <= 5'd20)
        else $error("record over twenty messages");
    a_rise_in: assert property (ev[0] && edge_q[1:0] == 2'b11 && din[0]
        |=> pend_q[0] && pin_q[0])
        else $error("rising edge not incoming");
    a_fall_in: assert property (ev[1] && edge_q[3:2] == 2'b01 && !din[1]
        |=> pend_q[1] && pin_q[1])
        else $error("falling edge not incoming");
    a_alarm_rec: assert property (alarm_req |-> alm1[23:16] >= 8'h64 &&
        alm1[23:16] <= 8'h72 && alm1[12:8] >= 5'd1 && alm1[12:8] <= 5'd20)
        else $error("alarm names bad record");
    a_reinit_flag: assert property (reinit_go |=> alm1[31:24] == 8'h20
        && do_spec)
        else $error("re-initialisation not flagged");
    a_spec_slot: assert property (do_spec |-> wdata[95:88] == 8'h02)
        else $error("special message slot wrong");
    a_frame_hdr: assert property (fval_q && fidx_q == 3'h0 |->
        fdat == 8'h5e)
        else $error("frame header wrong");

    c_signal_msg: cover property (do_sig && pin_q[pick_idx]);
    c_close_full: cover property (close && wr_cnt == 5'd19);
    c_ack_alarm: cover property (alarm_req ##1 ack);
    c_overflow: cover property (any && !can_write);
endmodule
